//--- hw/dual_timer_consts.svh
`ifndef DUAL_TIMER_CONSTS_SVH
`define DUAL_TIMER_CONSTS_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_LO_CTRL_A 4'h0
`define OFS_HI_CTRL_A 4'h1
`define OFS_LO_CTRL_B 4'h2
`define OFS_HI_CTRL_B 4'h3
`define OFS_LO_DATA 4'h4
`define OFS_HI_DATA 4'h5
`define OFS_PAIR_MODE 4'h6

// ****************************************
// reset values and fields
// ****************************************
`define REG_RST 8'h00
`define FLAG_BIT 2
`define CLK_SEL_EXT 3'h7
`define FILT_OFF 2'h0
`define FILT_REJ_H 2'h1
`define FILT_REJ_L 2'h2
`define FILT_REJ_HL 2'h3
`define CNT8_TOP 16'h00FF
`define CNT16_TOP 16'hFFFF

// ****************************************
// timing
// ****************************************
`define FILT_LEN 4

`endif

//--- hw/timer_pkg.sv
package timer_pkg;

  typedef enum logic [2:0] {
    MODE_ONESHOT = 3'h0,
    MODE_CONT = 3'h1,
    MODE_FREE = 3'h2,
    MODE_PWM_FIX = 3'h3,
    MODE_PWM_VAR = 3'h4,
    MODE_PULSE = 3'h5,
    MODE_CAP_CLR = 3'h6,
    MODE_CAP_FREE = 3'h7
  } mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WAIT = 3'h2,
    ST_RUN = 3'h4
  } runState_t;

  typedef struct packed {
    logic rsv;
    logic ie;
    logic [2:0] clkSel;
    mode_t mode;
  } ctrlA_t;

  typedef struct packed {
    logic [2:0] rsv;
    logic [1:0] edgeSel;
    logic flag;
    logic oe;
    logic start;
  } ctrlB_t;

  typedef struct packed {
    logic [1:0] rsv;
    logic hiLvl;
    logic loLvl;
    logic srcSerial;
    logic cascade;
    logic [1:0] filt;
  } pairMode_t;

endpackage

//--- hw/dual_8bit_composite_timer.sv
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "dual_timer_consts.svh"
module dual_8bit_composite_timer #(
  parameter int CHANNEL = 0,
  parameter int FILT_LEN = `FILT_LEN
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // prescaler ticks, taps 0..5 machine clock, 6 time-base
  input wire logic [6:0] presTick,
  // inputs
  input wire logic extIn,
  input wire logic serialIn,
  // pins and requests
  output logic [1:0] pinOut,
  output logic [1:0] pinOe,
  output logic [1:0] irq
);

  // ****************************************
  // state
  // ****************************************
  timer_pkg::ctrlA_t [1:0] ctrlA, next_ctrlA;
  timer_pkg::ctrlB_t [1:0] ctrlB, next_ctrlB;
  timer_pkg::pairMode_t pairMode, next_pairMode;
  timer_pkg::runState_t [1:0] st, next_st;
  logic [1:0][7:0] cnt, next_cnt, dataReg, next_dataReg, latch, next_latch;
  logic [1:0] outLvl, next_outLvl, prevIn, next_prevIn;
  logic [FILT_LEN-1:0] hist, next_hist;
  logic extFilt, next_extFilt, prevExt, next_prevExt;
  logic [7:0] next_regRdata;
  logic casc, serialSrc, extRise;
  logic [1:0] unitIn, rise, fall, tk, evStart, evEnd, evCap;
  function automatic logic isMeasure(timer_pkg::mode_t m);
    return m inside {timer_pkg::MODE_PULSE, timer_pkg::MODE_CAP_CLR, timer_pkg::MODE_CAP_FREE};
  endfunction
  function automatic logic isCapture(timer_pkg::mode_t m);
    return m inside {timer_pkg::MODE_CAP_CLR, timer_pkg::MODE_CAP_FREE};
  endfunction
  function automatic logic selTick(timer_pkg::ctrlA_t a, logic [6:0] taps, logic er);
    if (a.clkSel == `CLK_SEL_EXT) begin
      return er && !isMeasure(a.mode);
    end
    return taps[a.clkSel];
  endfunction
  // ****************************************
  // input routing and edges
  // ****************************************
  assign casc = pairMode.cascade && ctrlA[0].mode != timer_pkg::MODE_PWM_VAR;
  assign serialSrc = (CHANNEL == 1) ? 1'b0 : serialIn;
  assign unitIn[0] = pairMode.srcSerial ? serialSrc : extFilt;
  assign unitIn[1] = extFilt;
  assign rise = unitIn & ~prevIn;
  assign fall = ~unitIn & prevIn;
  assign extRise = extFilt & ~prevExt;
  always_comb begin
    for (int u = 0; u < 2; u++) begin
      tk[u] = selTick(ctrlA[u], presTick, extRise);
      evStart[u] = ctrlB[u].edgeSel[0] ? fall[u] : rise[u];
      if (ctrlB[u].edgeSel[1]) begin
        evEnd[u] = evStart[u];
        evCap[u] = rise[u] | fall[u];
      end else begin
        evEnd[u] = ctrlB[u].edgeSel[0] ? rise[u] : fall[u];
        evCap[u] = evStart[u];
      end
    end
  end
  // ****************************************
  // noise filter
  // ****************************************
  always_comb begin
    next_hist = {hist[FILT_LEN-2:0], extIn};
    next_prevExt = extFilt;
    next_extFilt = extFilt;
    unique case (pairMode.filt)
      `FILT_OFF: next_extFilt = extIn;
      `FILT_REJ_H: begin
        if (&hist) next_extFilt = 1'b1;
        else if (!hist[0]) next_extFilt = 1'b0;
      end
      `FILT_REJ_L: begin
        if (~|hist) next_extFilt = 1'b0;
        else if (hist[0]) next_extFilt = 1'b1;
      end
      `FILT_REJ_HL: begin
        if (&hist) next_extFilt = 1'b1;
        else if (~|hist) next_extFilt = 1'b0;
      end
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hist <= '0;
      extFilt <= 1'b0;
      prevExt <= 1'b0;
    end else begin
      hist <= next_hist;
      extFilt <= next_extFilt;
      prevExt <= next_prevExt;
    end
  end
  // ****************************************
  // registers and counters
  // ****************************************
  always_comb begin
    logic [15:0] v, cmp, top, nv;
    logic wide, hit, capt, reload, lvl;
    timer_pkg::mode_t md;
    v = '0;
    cmp = '0;
    top = '0;
    nv = '0;
    wide = 1'b0;
    hit = 1'b0;
    capt = 1'b0;
    reload = 1'b0;
    lvl = 1'b0;
    md = timer_pkg::MODE_ONESHOT;
    next_ctrlA = ctrlA;
    next_ctrlB = ctrlB;
    next_pairMode = pairMode;
    next_st = st;
    next_cnt = cnt;
    next_dataReg = dataReg;
    next_latch = latch;
    next_outLvl = outLvl;
    next_prevIn = unitIn;
    next_regRdata = 8'h00;
    if (regWr) begin
      unique case (regAddr)
        `OFS_LO_CTRL_A: next_ctrlA[0] = regWdata;
        `OFS_HI_CTRL_A: next_ctrlA[1] = regWdata;
        `OFS_LO_CTRL_B, `OFS_HI_CTRL_B: begin
          next_ctrlB[regAddr[0]] = regWdata;
          next_ctrlB[regAddr[0]].flag = ctrlB[regAddr[0]].flag & regWdata[`FLAG_BIT];
        end
        `OFS_LO_DATA: next_dataReg[0] = regWdata;
        `OFS_HI_DATA: next_dataReg[1] = regWdata;
        `OFS_PAIR_MODE: next_pairMode = regWdata;
        default: ;
      endcase
      next_ctrlA[0].rsv = 1'b0;
      next_ctrlA[1].rsv = 1'b0;
      next_ctrlB[0].rsv = '0;
      next_ctrlB[1].rsv = '0;
      next_pairMode.rsv = '0;
      next_pairMode.loLvl = 1'b0;
      next_pairMode.hiLvl = 1'b0;
    end
    if (regRd) begin
      unique case (regAddr)
        `OFS_LO_CTRL_A: next_regRdata = ctrlA[0];
        `OFS_HI_CTRL_A: next_regRdata = ctrlA[1];
        `OFS_LO_CTRL_B: next_regRdata = ctrlB[0];
        `OFS_HI_CTRL_B: next_regRdata = ctrlB[1];
        `OFS_LO_DATA: next_regRdata = dataReg[0];
        `OFS_HI_DATA: next_regRdata = dataReg[1];
        `OFS_PAIR_MODE: next_regRdata = {2'b00, outLvl[1], outLvl[0], pairMode[3:0]};
        default: next_regRdata = 8'h00;
      endcase
    end
    for (int u = 0; u < 2; u++) begin
      if (!(u == 1 && casc)) begin
        wide = casc && u == 0;
        md = ctrlA[u].mode;
        v = wide ? {cnt[1], cnt[0]} : {8'h00, cnt[u]};
        cmp = wide ? {latch[1], latch[0]} : {8'h00, latch[u]};
        top = wide ? `CNT16_TOP : `CNT8_TOP;
        nv = v;
        hit = 1'b0;
        capt = 1'b0;
        reload = 1'b0;
        lvl = outLvl[u];
        if (!next_ctrlB[u].start) begin
          next_st[u] = timer_pkg::ST_IDLE;
        end else if (st[u] == timer_pkg::ST_IDLE) begin
          nv = '0;
          reload = 1'b1;
          next_st[u] = (md == timer_pkg::MODE_PULSE) ? timer_pkg::ST_WAIT : timer_pkg::ST_RUN;
          if (md == timer_pkg::MODE_PULSE) lvl = 1'b0;
        end else begin
          unique case (md)
            timer_pkg::MODE_ONESHOT, timer_pkg::MODE_CONT, timer_pkg::MODE_FREE: begin
              if (tk[u]) begin
                nv = (v + 16'h0001) & top;
                reload = (v == top);
                if (v == cmp) begin
                  hit = 1'b1;
                  lvl = ~outLvl[u];
                  if (md == timer_pkg::MODE_ONESHOT) begin
                    nv = v;
                    next_ctrlB[u].start = 1'b0;
                    next_st[u] = timer_pkg::ST_IDLE;
                  end else if (md == timer_pkg::MODE_CONT) begin
                    nv = '0;
                    reload = 1'b1;
                  end
                end
              end
            end
            timer_pkg::MODE_PWM_FIX: begin
              lvl = v < cmp;
              if (tk[u]) begin
                nv = (v + 16'h0001) & top;
                reload = (v == top);
              end
            end
            timer_pkg::MODE_PWM_VAR: begin
              if (u == 0) begin
                lvl = v >= {8'h00, latch[1]};
                if (tk[u]) begin
                  nv = (v >= cmp) ? 16'h0000 : v + 16'h0001;
                  reload = (v >= cmp);
                  hit = reload;
                end
              end
            end
            timer_pkg::MODE_PULSE: begin
              if (st[u] == timer_pkg::ST_WAIT) begin
                if (evStart[u]) begin
                  nv = '0;
                  next_st[u] = timer_pkg::ST_RUN;
                  lvl = 1'b1;
                end
              end else begin
                if (tk[u]) nv = (v + 16'h0001) & top;
                if (evEnd[u]) begin
                  capt = 1'b1;
                  hit = 1'b1;
                  if (ctrlB[u].edgeSel[1]) begin
                    nv = '0;
                  end else begin
                    next_st[u] = timer_pkg::ST_WAIT;
                    lvl = 1'b0;
                  end
                end
              end
            end
            timer_pkg::MODE_CAP_CLR: begin
              if (evCap[u]) begin
                capt = 1'b1;
                hit = 1'b1;
                nv = '0;
              end else if (tk[u]) begin
                nv = (v + 16'h0001) & top;
              end
            end
            timer_pkg::MODE_CAP_FREE: begin
              capt = evCap[u];
              hit = evCap[u];
              if (tk[u]) nv = (v + 16'h0001) & top;
            end
          endcase
        end
        next_outLvl[u] = lvl;
        if (hit) next_ctrlB[u].flag = 1'b1;
        if (wide) begin
          next_cnt[1] = nv[15:8];
          next_cnt[0] = nv[7:0];
        end else begin
          next_cnt[u] = nv[7:0];
        end
        if (capt) begin
          next_dataReg[u] = v[7:0];
          if (wide) next_dataReg[1] = v[15:8];
        end
        if (reload) begin
          next_latch[u] = dataReg[u];
          if (wide || md == timer_pkg::MODE_PWM_VAR) next_latch[1] = dataReg[1];
        end
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrlA <= {`REG_RST, `REG_RST};
      ctrlB <= {`REG_RST, `REG_RST};
      pairMode <= `REG_RST;
      st <= {timer_pkg::ST_IDLE, timer_pkg::ST_IDLE};
      cnt <= '0;
      dataReg <= '0;
      latch <= '0;
      outLvl <= '0;
      prevIn <= '0;
      regRdata <= 8'h00;
    end else begin
      ctrlA <= next_ctrlA;
      ctrlB <= next_ctrlB;
      pairMode <= next_pairMode;
      st <= next_st;
      cnt <= next_cnt;
      dataReg <= next_dataReg;
      latch <= next_latch;
      outLvl <= next_outLvl;
      prevIn <= next_prevIn;
      regRdata <= next_regRdata;
    end
  end
  // ****************************************
  // pins and requests
  // ****************************************
  always_comb begin
    for (int u = 0; u < 2; u++) begin
      pinOut[u] = outLvl[u];
      pinOe[u] = ctrlB[u].oe && !isCapture(ctrlA[u].mode);
      irq[u] = ctrlB[u].flag && ctrlA[u].ie;
    end
  end
  // ****************************************
  // checks
  // ****************************************
  logic loRun;
  assign loRun = st[0] == timer_pkg::ST_RUN && ctrlB[0].start && !casc && !regWr;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  chk_flag_sticky: assert property (
    ctrlB[0].flag && !(regWr && regAddr == `OFS_LO_CTRL_B) |=> ctrlB[0].flag
  ) else $error("flag dropped without a clear");
  chk_oneshot_halt: assert property (
    loRun && ctrlA[0].mode == timer_pkg::MODE_ONESHOT && tk[0] && cnt[0] == latch[0]
    |=> st[0] == timer_pkg::ST_IDLE && ctrlB[0].flag && outLvl[0] != $past(outLvl[0])
  ) else $error("one-shot match did not halt");
  chk_cont_restart: assert property (
    loRun && ctrlA[0].mode == timer_pkg::MODE_CONT && tk[0] && cnt[0] == latch[0]
    |=> cnt[0] == 8'h00 && ctrlB[0].flag
  ) else $error("continuous match did not restart");
  chk_free_wrap: assert property (
    loRun && ctrlA[0].mode == timer_pkg::MODE_FREE && tk[0] && cnt[0] == 8'hFF
    |=> cnt[0] == 8'h00
  ) else $error("free-run did not wrap");
  chk_latch_hold: assert property (
    loRun && ctrlA[0].mode == timer_pkg::MODE_CONT && !tk[0] |=> $stable(latch[0])
  ) else $error("latch moved between reloads");
  chk_pwm_level: assert property (
    loRun && ctrlA[0].mode == timer_pkg::MODE_PWM_FIX
    |=> outLvl[0] == ($past(cnt[0]) < $past(latch[0]))
  ) else $error("fixed pwm level wrong");
  chk_capture_clear: assert property (
    loRun && ctrlA[0].mode == timer_pkg::MODE_CAP_CLR && evCap[0]
    |=> dataReg[0] == $past(cnt[0]) && cnt[0] == 8'h00
  ) else $error("clear capture wrong");
  chk_capture_free: assert property (
    loRun && ctrlA[0].mode == timer_pkg::MODE_CAP_FREE && evCap[0]
    |=> dataReg[0] == $past(cnt[0]) && ctrlB[0].flag
    && cnt[0] == 8'($past(cnt[0]) + 8'($past(tk[0])))
  ) else $error("free capture wrong");
  chk_cascade_carry: assert property (
    casc && st[0] == timer_pkg::ST_RUN && ctrlB[0].start && !regWr
    && ctrlA[0].mode inside {timer_pkg::MODE_FREE, timer_pkg::MODE_CONT} && tk[0]
    && cnt[0] == 8'hFF
    && (ctrlA[0].mode == timer_pkg::MODE_FREE || {cnt[1], cnt[0]} != {latch[1], latch[0]})
    |=> cnt[1] == 8'($past(cnt[1]) + 8'h01)
  ) else $error("high byte missed the carry");
  chk_capture_pin: assert property (
    isCapture(ctrlA[0].mode) |-> !pinOe[0]
  ) else $error("pin driven in capture");
  cov_oneshot: cover property (loRun && ctrlA[0].mode == timer_pkg::MODE_ONESHOT
    && tk[0] && cnt[0] == latch[0]);
  cov_pulse_end: cover property (loRun && ctrlA[0].mode == timer_pkg::MODE_PULSE && evEnd[0]);
  cov_capture: cover property (loRun && ctrlA[0].mode == timer_pkg::MODE_CAP_FREE && evCap[0]);
  cov_cascade: cover property (casc && tk[0] && cnt[0] == 8'hFF);
endmodule

//--- sim/ext_signal_model.sv
`timescale 1ns/1ps
// ****************************************
// external input model
// ****************************************
module ext_signal_model (
  // clock
  input wire logic clk_sys,
  // driven inputs
  output logic extIn,
  output logic serialIn
);
  initial begin
    extIn = 1'b0;
    serialIn = 1'b0;
  end
  // high pulse on the pin or the serial line
  task automatic pulse(input bit onSer, input int width);
    @(posedge clk_sys);
    if (onSer) begin
      serialIn <= 1'b1;
    end else begin
      extIn <= 1'b1;
    end
    repeat (width) @(posedge clk_sys);
    serialIn <= 1'b0;
    extIn <= 1'b0;
  endtask
  // pulse train, rising edges one period apart
  task automatic train(input int n, input int width, input int period);
    for (int i = 0; i < n; i++) begin
      pulse(1'b0, width);
      repeat (period - width - 1) @(posedge clk_sys);
    end
  endtask
endmodule

//--- sim/tb_top.sv
`timescale 1ns/1ps
`include "dual_timer_consts.svh"
module tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdata;
  logic [6:0] presTick = 7'h00;
  logic [7:0] divCnt = 8'h00;
  logic extIn;
  logic serialIn;
  logic [1:0] pinOut;
  logic [1:0] pinOe;
  logic [1:0] irq;
  logic [7:0] rdVal;
  logic [7:0] capA;
  int mismatches = 0;
  int testsRun = 0;
  int runLen;
  // timing cases: ctrl A, pair mode, data lo, data hi, level, length
  logic [7:0] caseA [6] = '{8'h01, 8'h09, 8'h02, 8'h03, 8'h04, 8'h01};
  logic [7:0] casePair [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04};
  logic [7:0] caseLo [6] = '{8'h03, 8'h03, 8'h03, 8'h40, 8'h09, 8'h01};
  logic [7:0] caseHi [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h01};
  logic caseLv [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
  int caseLen [6] = '{4, 8, 256, 64, 3, 258};

  dual_8bit_composite_timer #(.CHANNEL(0), .FILT_LEN(4)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .presTick(presTick),
    .extIn(extIn), .serialIn(serialIn), .pinOut(pinOut), .pinOe(pinOe), .irq(irq)
  );
  ext_signal_model ext_u (.clk_sys(clk_sys), .extIn(extIn), .serialIn(serialIn));

  // ****************************************
  // clock and prescaler taps
  // ****************************************
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    divCnt <= divCnt + 8'h01;
    for (int k = 0; k < 7; k++) begin
      presTick[k] <= ((divCnt & ((8'h01 << k) - 8'h01)) == 8'h00);
    end
  end

  // ****************************************
  // bus and compare tasks
  // ****************************************
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic miss(input string what);
    mismatches++;
    $display("unexpected at %0t: %s", $time, what);
  endtask
  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp, input string what);
    testsRun++;
    if (got !== exp) miss(what);
  endtask
  task automatic chkBit(input logic got, input logic exp, input string what);
    testsRun++;
    if (got !== exp) miss(what);
  endtask
  task automatic chkCount(input int got, input int lo, input int hi, input string what);
    testsRun++;
    if (got < lo || got > hi) miss(what);
  endtask
  task automatic measure(input logic lv, output int n);
    int i;
    n = 0;
    for (i = 0; i < 3000 && pinOut[0] === lv; i++) begin
      @(posedge clk_sys);
      #1;
    end
    for (i = 0; i < 3000 && pinOut[0] !== lv; i++) begin
      @(posedge clk_sys);
      #1;
    end
    for (i = 0; i < 3000 && pinOut[0] === lv; i++) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask
  task automatic waitIrq();
    for (int i = 0; i < 200 && irq[0] !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
  endtask
  task automatic giveVerdict();
    $display("counts: %0d compares, %0d mismatches", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    #200000;
    miss("watchdog");
    giveVerdict();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    wr(4'hB, 8'hFF);
    for (int a = 0; a < 8; a++) begin
      rd((a == 7) ? 4'hB : a[3:0], rdVal);
      chkByte(rdVal, `REG_RST, "reset value");
    end
    $display("test reset done");
    wr(`OFS_LO_DATA, 8'h02);
    wr(`OFS_LO_CTRL_A, 8'h40);
    wr(`OFS_LO_CTRL_B, 8'h03);
    repeat (10) @(posedge clk_sys);
    #1 chkBit(pinOut[0], 1'b1, "oneshot pin");
    chkBit(irq[0], 1'b1, "oneshot irq");
    chkBit(pinOe[0], 1'b1, "pin enable");
    rd(`OFS_LO_CTRL_B, rdVal);
    chkByte(rdVal, 8'h06, "oneshot halt");
    rd(`OFS_PAIR_MODE, rdVal);
    chkByte(rdVal, 8'h10, "level report");
    wr(`OFS_LO_CTRL_B, 8'h00);
    chkBit(irq[0], 1'b0, "flag clear");
    chkBit(pinOe[0], 1'b0, "pin disable");
    $display("test oneshot done");
    for (int c = 0; c < 6; c++) begin
      wr(`OFS_PAIR_MODE, casePair[c]);
      wr(`OFS_LO_DATA, caseLo[c]);
      wr(`OFS_HI_DATA, caseHi[c]);
      wr(`OFS_LO_CTRL_A, caseA[c]);
      wr(`OFS_LO_CTRL_B, 8'h03);
      measure(caseLv[c], runLen);
      chkCount(runLen, caseLen[c], caseLen[c], "run length");
      wr(`OFS_LO_CTRL_B, 8'h00);
    end
    $display("test timing done");
    wr(`OFS_PAIR_MODE, 8'h00);
    wr(`OFS_LO_CTRL_A, 8'h45);
    wr(`OFS_LO_CTRL_B, 8'h03);
    ext_u.pulse(1'b0, 20);
    waitIrq();
    chkBit(irq[0], 1'b1, "pulse irq");
    chkBit(pinOe[0], 1'b1, "pulse enable");
    rd(`OFS_LO_DATA, rdVal);
    chkCount(int'(rdVal), 19, 21, "pulse width");
    wr(`OFS_LO_CTRL_B, 8'h00);
    $display("test pulse done");
    for (int m = 0; m < 2; m++) begin
      wr(`OFS_LO_CTRL_A, (m == 1) ? 8'h47 : 8'h46);
      wr(`OFS_LO_CTRL_B, 8'h03);
      fork
        ext_u.train(2, 5, 40);
        begin
          waitIrq();
          rd(`OFS_LO_DATA, capA);
          wr(`OFS_LO_CTRL_B, 8'h03);
        end
      join
      waitIrq();
      rd(`OFS_LO_DATA, rdVal);
      chkBit(pinOe[0], 1'b0, "capture enable");
      if (m == 1) begin
        chkCount(int'(8'(rdVal - capA)), 40, 40, "free capture");
      end else begin
        chkCount(int'(rdVal), 39, 40, "clear capture");
      end
      wr(`OFS_LO_CTRL_B, 8'h00);
    end
    $display("test capture done");
    for (int f = 0; f < 4; f++) begin
      wr(`OFS_PAIR_MODE, f[7:0]);
      wr(`OFS_LO_CTRL_B, 8'h03);
      ext_u.pulse(1'b0, 2);
      repeat (12) @(posedge clk_sys);
      #1 chkBit(irq[0], f[0] ? 1'b0 : 1'b1, "filter");
      wr(`OFS_LO_CTRL_B, 8'h00);
    end
    $display("test filter done");
    wr(`OFS_PAIR_MODE, 8'h08);
    wr(`OFS_LO_CTRL_B, 8'h03);
    ext_u.pulse(1'b1, 6);
    repeat (12) @(posedge clk_sys);
    #1 chkBit(irq[0], 1'b1, "serial input");
    chkBit(irq[1], 1'b0, "high timer idle");
    chkBit(pinOe[1], 1'b0, "high pin idle");
    chkBit(pinOut[1], 1'b0, "high level idle");
    $display("test serial done");
    giveVerdict();
  end
endmodule
